// File: core/dcms_params.svh
/*
  Constants of the dual converter mode sequencer: register addresses,
  reset values, field positions, mode codes and cadence counts.
  Assumes inclusion by bare name from every file that needs them.
*/
// Functional notes
// - Idle holds filter and modulator in reset, modulator clocks keep running.
// - Single mode converts once per enabled converter, then mode returns to power-down.
// - Continuous mode refreshes results at the filter rate register cadence.
// - Internal zero-scale calibration shorts each enabled converter input internally.
// - Internal full-scale calibration connects the reference chosen by its select bit.
// - Any mode field write resets both converters, except auxiliary-only cases.
// - Primary control write while enabled, or primary enable rising, resets both.
// - Auxiliary control write or auxiliary enable rising resets only the auxiliary.
// - Auxiliary realigns to primary outputs; first result within three primary periods.
// - Writing a calibration code clears both ready flags, then calibration starts.
// - Calibration end writes coefficients, updates status, sets mode to power-down.
// - Auxiliary calibration on temperature sensor skips coefficients, sets ready and error.
// - Primary control resets to 07H: int ref (XREF bit 6 clear), channel pair, unipolar, range.
// - Mode code 000 is power-down and the reset default.
// - A set ready flag blocks further result or coefficient writes.
`ifndef DCMS_PARAMS_SVH
`define DCMS_PARAMS_SVH

// Register addresses
`define DCMS_ADDR_MODE     8'hd1
`define DCMS_ADDR_PCTRL    8'hd2
`define DCMS_ADDR_ACTRL    8'hd3
`define DCMS_ADDR_RATE     8'hd4
`define DCMS_ADDR_STAT     8'hd8

// Reset values
`define DCMS_MODE_RST      8'h00
`define DCMS_PCTRL_RST     8'h07
`define DCMS_ACTRL_RST     8'h00
`define DCMS_RATE_RST      8'h45

// Field positions
`define DCMS_MODE_PEN      5
`define DCMS_MODE_AEN      4
`define DCMS_CTRL_XREF     6
`define DCMS_CTRL_MASK     8'h7f
`define DCMS_ACTRL_MASK    8'h78
`define DCMS_MODE_MASK     8'h37

// Mode field codes
`define DCMS_MD_PDOWN      3'h0
`define DCMS_MD_IDLE       3'h1
`define DCMS_MD_SINGLE     3'h2
`define DCMS_MD_CONT       3'h3
`define DCMS_MD_IZS        3'h4
`define DCMS_MD_IFS        3'h5
`define DCMS_MD_SZS        3'h6
`define DCMS_MD_SFS        3'h7

// Auxiliary channel code that routes the temperature sensor
`define DCMS_ACH_TEMP      2'h2
`define DCMS_ACH_HI        5
`define DCMS_ACH_LO        4

// Cadence: period = (rate + 1) << shift core cycles
`define DCMS_RATE_SHIFT    4
`define DCMS_SETTLE_LAST   2'h2

`endif

// File: core/dcms_pkg.sv
/*
  Types of the dual converter mode sequencer: state records of the
  cadence generator and of the top-level sequencer.
  Assumes the constants header is compiled alongside.
*/
`default_nettype none

package dcms_pkg;

  // Cadence generator state
  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } dcms_rate_st_t;

  // Register file of the sequencer
  typedef struct packed {
    logic       pen;
    logic       aen;
    logic [2:0] md;
    logic [7:0] pctrl;
    logic [7:0] actrl;
    logic [7:0] rate;
  } dcms_regs_t;

  // Status flags
  typedef struct packed {
    logic primary_ready_flag;
    logic aux_ready_flag;
    logic cal;
    logic noxref;
    logic err0;
    logic aux_error_flag;
  } dcms_flags_t;

  // Analog-side controls, all registered
  typedef struct packed {
    logic p_filt_rst;
    logic a_filt_rst;
    logic p_pwr_dn;
    logic a_pwr_dn;
    logic mod_clk_run;
    logic p_short;
    logic a_short;
    logic p_ref_conn;
    logic a_ref_conn;
  } dcms_ana_t;

  // Whole sequencer state
  typedef struct packed {
    dcms_regs_t  regs;
    dcms_flags_t flg;
    dcms_ana_t   ana;
    logic [1:0]  p_settle;
    logic [1:0]  a_settle;
    logic        p_done;
    logic        a_done;
    logic        restart;
    logic [23:0] p_result;
    logic [15:0] a_result;
    logic [23:0] p_offset;
    logic [23:0] p_gain;
    logic [15:0] a_offset;
    logic [15:0] a_gain;
    logic [7:0]  rdata;
  } dcms_state_t;

endpackage

`default_nettype wire

// File: core/dcms_rate_gen.sv
/*
  Output cadence generator: one tick per primary output period.
  Assumes restart is a registered pulse from the sequencer.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dcms_params.svh"

module dcms_rate_gen (
  input  wire logic       ref_clk, // Core clock
  input  wire logic       rst_b,   // Sync reset, active low
  input  wire logic       restart, // Realign cadence to zero
  input  wire logic       run,     // Some converter is converting
  input  wire logic [7:0] rate,    // Filter rate register
  output logic            tick     // One-cycle output cadence pulse
);

  dcms_pkg::dcms_rate_st_t st_r;
  dcms_pkg::dcms_rate_st_t st_nxt;
  logic [15:0]             period_m1;

  // Period scales with the rate register
  assign period_m1 = (({8'h00, rate} + 16'h0001) << `DCMS_RATE_SHIFT) - 16'h0001;

  // Counter; stopped while nothing runs so cadence starts from a reset
  always_comb begin
    st_nxt      = st_r;
    st_nxt.tick = 1'b0;
    if (restart || !run) begin
      st_nxt.cnt = 16'h0000;
    end else if (st_r.cnt >= period_m1) begin
      st_nxt.cnt  = 16'h0000;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick = st_r.tick;

endmodule

`default_nettype wire

// File: core/dcms_top.sv
/*
  Dual converter mode sequencer: mode, control, rate and status registers
  on the special function register port, conversion and calibration
  sequencing, and control levels towards both analog converters.
  Assumes a single-cycle register write/read strobe in the core clock
  domain and filter data that is valid whenever a cadence tick occurs.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dcms_params.svh"

module dcms_top (
  input  wire logic        ref_clk,          // Core clock, 40 MHz
  input  wire logic        rst_b,            // Sync reset, active low
  input  wire logic        sfr_we,           // Register write strobe
  input  wire logic        sfr_re,           // Register read strobe
  input  wire logic [7:0]  sfr_addr,         // Register address
  input  wire logic [7:0]  sfr_wdata,        // Write data
  output logic      [7:0]  sfr_rdata,        // Read data, one cycle after sfr_re
  input  wire logic [23:0] prim_raw,         // Primary filter output word
  input  wire logic [15:0] aux_raw,          // Auxiliary filter output word
  input  wire logic        prim_clamp,       // Primary word clamped
  input  wire logic        aux_clamp,        // Auxiliary word clamped
  input  wire logic        ref_missing,      // External reference absent
  output logic             prim_filt_rst,    // Primary filter/modulator reset
  output logic             aux_filt_rst,     // Auxiliary filter/modulator reset
  output logic             prim_pwr_dn,      // Primary powered down
  output logic             aux_pwr_dn,       // Auxiliary powered down
  output logic             mod_clk_run,      // Modulator clocks supplied
  output logic             prim_in_short,    // Primary input internally shorted
  output logic             aux_in_short,     // Auxiliary input internally shorted
  output logic             prim_ref_conn,    // Primary input tied to reference
  output logic             aux_ref_conn,     // Auxiliary input tied to reference
  output logic [6:0]       prim_cfg,         // Primary control fields
  output logic [6:0]       aux_cfg,          // Auxiliary control fields
  output logic [23:0]      prim_result_regs, // Primary result
  output logic [15:0]      aux_result_regs,  // Auxiliary result
  output logic [23:0]      prim_offset_coef, // Primary offset coefficient
  output logic [23:0]      prim_gain_coef,   // Primary gain coefficient
  output logic [15:0]      aux_offset_coef,  // Auxiliary offset coefficient
  output logic [15:0]      aux_gain_coef     // Auxiliary gain coefficient
);

  dcms_pkg::dcms_state_t q_r;
  dcms_pkg::dcms_state_t q_nxt;
  logic                  tick;
  logic                  run;
  logic                  wr_mode;
  logic                  wr_pctrl;
  logic                  wr_actrl;
  logic                  rst_both;
  logic                  rst_aux;
  logic                  p_act;
  logic                  a_act;
  logic                  p_evt;
  logic                  a_evt;
  logic                  is_cal;
  logic                  one_shot;
  logic                  zero_scale;
  logic                  a_temp;
  logic [2:0]            md_n;

  // Cadence shared by both converters keeps the auxiliary in step
  dcms_rate_gen i_dcms_rate_gen (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .restart (q_r.restart),
    .run     (run),
    .rate    (q_r.regs.rate),
    .tick    (tick)
  );

  // Register write decode
  assign wr_mode  = sfr_we && (sfr_addr == `DCMS_ADDR_MODE);
  assign wr_pctrl = sfr_we && (sfr_addr == `DCMS_ADDR_PCTRL);
  assign wr_actrl = sfr_we && (sfr_addr == `DCMS_ADDR_ACTRL);

  // mode writes, except a lone auxiliary enable rise, and primary changes reset both
  assign rst_both = (wr_mode && ((sfr_wdata[2:0] != q_r.regs.md)
                                 || (sfr_wdata[`DCMS_MODE_PEN] != q_r.regs.pen)
                                 || !(sfr_wdata[`DCMS_MODE_AEN] && !q_r.regs.aen)))
                    || (wr_pctrl && q_r.regs.pen);
  assign rst_aux  = rst_both || wr_actrl
                    || (wr_mode && sfr_wdata[`DCMS_MODE_AEN] && !q_r.regs.aen);

  // only enabled converters follow the mode
  assign p_act = q_r.regs.pen && (q_r.regs.md >= `DCMS_MD_SINGLE);
  assign a_act = q_r.regs.aen && (q_r.regs.md >= `DCMS_MD_SINGLE);
  assign run   = p_act || a_act;

  assign is_cal     = q_r.regs.md[2];
  assign one_shot   = (q_r.regs.md == `DCMS_MD_SINGLE) || is_cal;
  assign zero_scale = !q_r.regs.md[0];
  assign a_temp     = (q_r.regs.actrl[`DCMS_ACH_HI:`DCMS_ACH_LO] == `DCMS_ACH_TEMP);

  // output after settling ticks, auxiliary counts primary cadence
  assign p_evt = tick && p_act && !q_r.p_done && (q_r.p_settle == `DCMS_SETTLE_LAST)
                 && !rst_both;
  assign a_evt = tick && a_act && !q_r.a_done && (q_r.a_settle == `DCMS_SETTLE_LAST)
                 && !rst_aux;

  always_comb begin
    q_nxt         = q_r;
    q_nxt.restart = rst_both;
    md_n          = q_r.regs.md;

    // Register writes
    if (wr_mode) begin
      q_nxt.regs.pen = sfr_wdata[`DCMS_MODE_PEN];
      q_nxt.regs.aen = sfr_wdata[`DCMS_MODE_AEN];
      md_n           = sfr_wdata[2:0];
      // new mode clears ready, calibration and error flags
      q_nxt.flg.primary_ready_flag = 1'b0;
      q_nxt.flg.aux_ready_flag = 1'b0;
      q_nxt.flg.cal  = 1'b0;
      q_nxt.flg.err0 = 1'b0;
      q_nxt.flg.aux_error_flag = 1'b0;
    end
    if (wr_pctrl) begin
      q_nxt.regs.pctrl = sfr_wdata & `DCMS_CTRL_MASK;
    end
    if (wr_actrl) begin
      q_nxt.regs.actrl = sfr_wdata & `DCMS_ACTRL_MASK;
    end
    if (sfr_we && (sfr_addr == `DCMS_ADDR_RATE)) begin
      q_nxt.regs.rate = sfr_wdata;
    end
    // Software clears a ready flag by writing it zero
    if (sfr_we && (sfr_addr == `DCMS_ADDR_STAT)) begin
      q_nxt.flg.primary_ready_flag = q_r.flg.primary_ready_flag && sfr_wdata[7];
      q_nxt.flg.aux_ready_flag = q_r.flg.aux_ready_flag && sfr_wdata[6];
    end

    // Settling counters restart on converter reset
    if (rst_both) begin
      q_nxt.p_settle = 2'h0;
      q_nxt.p_done   = 1'b0;
    end else if (tick && p_act && (q_r.p_settle != `DCMS_SETTLE_LAST)) begin
      q_nxt.p_settle = q_r.p_settle + 2'h1;
    end
    if (rst_aux) begin
      q_nxt.a_settle = 2'h0;
      q_nxt.a_done   = 1'b0;
    end else if (tick && a_act && (q_r.a_settle != `DCMS_SETTLE_LAST)) begin
      q_nxt.a_settle = q_r.a_settle + 2'h1;
    end

    // results land only while ready is clear; set wins over clear
    if (p_evt && !q_r.flg.primary_ready_flag) begin
      if (!is_cal) begin
        q_nxt.p_result = prim_raw;
        q_nxt.flg.err0 = prim_clamp;
      end else if (zero_scale) begin
        q_nxt.p_offset = prim_raw;
      end else begin
        q_nxt.p_gain = prim_raw;
      end
      q_nxt.flg.primary_ready_flag = 1'b1;
    end
    if (a_evt && !q_r.flg.aux_ready_flag) begin
      if (!is_cal) begin
        q_nxt.a_result = aux_raw;
        q_nxt.flg.aux_error_flag = aux_clamp;
      end else if (a_temp) begin
        q_nxt.flg.aux_error_flag = 1'b1;
      end else if (zero_scale) begin
        q_nxt.a_offset = aux_raw;
      end else begin
        q_nxt.a_gain = aux_raw;
      end
      q_nxt.flg.aux_ready_flag = 1'b1;
    end
    if (p_evt && one_shot) begin
      q_nxt.p_done = 1'b1;
    end
    if (a_evt && one_shot) begin
      q_nxt.a_done = 1'b1;
    end

    // one-shot modes fall back to power-down when all done
    if (!wr_mode && one_shot && run
        && (!p_act || q_r.p_done) && (!a_act || q_r.a_done)) begin
      md_n = `DCMS_MD_PDOWN;
      if (is_cal) begin
        q_nxt.flg.cal = 1'b1;
      end
    end
    q_nxt.regs.md = md_n;

    // Reference detect only while a converter runs
    q_nxt.flg.noxref = ref_missing && run;

    // idle and reset hold filters, modulator clocks stay on
    q_nxt.ana.p_filt_rst  = !p_act || rst_both;
    q_nxt.ana.a_filt_rst  = !a_act || rst_aux;
    q_nxt.ana.p_pwr_dn    = !q_r.regs.pen || (q_r.regs.md == `DCMS_MD_PDOWN);
    q_nxt.ana.a_pwr_dn    = !q_r.regs.aen || (q_r.regs.md == `DCMS_MD_PDOWN);
    q_nxt.ana.mod_clk_run = !q_nxt.ana.p_pwr_dn || !q_nxt.ana.a_pwr_dn;
    q_nxt.ana.p_short = p_act && (q_r.regs.md == `DCMS_MD_IZS);
    q_nxt.ana.a_short = a_act && (q_r.regs.md == `DCMS_MD_IZS);
    // internal full-scale picks reference by select bit
    q_nxt.ana.p_ref_conn = p_act && (q_r.regs.md == `DCMS_MD_IFS);
    q_nxt.ana.a_ref_conn = a_act && (q_r.regs.md == `DCMS_MD_IFS);

    // Registered read data; unmapped addresses read zero
    if (sfr_re) begin
      case (sfr_addr)
        `DCMS_ADDR_MODE: begin
          q_nxt.rdata = {2'h0, q_r.regs.pen, q_r.regs.aen, 1'b0, q_r.regs.md};
        end
        `DCMS_ADDR_PCTRL: begin
          q_nxt.rdata = q_r.regs.pctrl;
        end
        `DCMS_ADDR_ACTRL: begin
          q_nxt.rdata = q_r.regs.actrl;
        end
        `DCMS_ADDR_RATE: begin
          q_nxt.rdata = q_r.regs.rate;
        end
        `DCMS_ADDR_STAT: begin
          q_nxt.rdata = {q_r.flg, 2'h0};
        end
        default: begin
          q_nxt.rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      q_r             <= '0;
      q_r.regs.pctrl  <= `DCMS_PCTRL_RST;
      q_r.regs.actrl  <= `DCMS_ACTRL_RST;
      q_r.regs.rate   <= `DCMS_RATE_RST;
      q_r.regs.md     <= `DCMS_MD_PDOWN;
      q_r.ana.p_filt_rst <= 1'b1;
      q_r.ana.a_filt_rst <= 1'b1;
      q_r.ana.p_pwr_dn   <= 1'b1;
      q_r.ana.a_pwr_dn   <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end

  // Outputs straight from the state register
  assign sfr_rdata        = q_r.rdata;
  assign prim_filt_rst    = q_r.ana.p_filt_rst;
  assign aux_filt_rst     = q_r.ana.a_filt_rst;
  assign prim_pwr_dn      = q_r.ana.p_pwr_dn;
  assign aux_pwr_dn       = q_r.ana.a_pwr_dn;
  assign mod_clk_run      = q_r.ana.mod_clk_run;
  assign prim_in_short    = q_r.ana.p_short;
  assign aux_in_short     = q_r.ana.a_short;
  assign prim_ref_conn    = q_r.ana.p_ref_conn;
  assign aux_ref_conn     = q_r.ana.a_ref_conn;
  assign prim_cfg         = q_r.regs.pctrl[6:0];
  assign aux_cfg          = q_r.regs.actrl[6:0];
  assign prim_result_regs = q_r.p_result;
  assign aux_result_regs  = q_r.a_result;
  assign prim_offset_coef = q_r.p_offset;
  assign prim_gain_coef   = q_r.p_gain;
  assign aux_offset_coef  = q_r.a_offset;
  assign aux_gain_coef    = q_r.a_gain;

endmodule

`default_nettype wire

// File: testbench/dcms_checker.sv
/*
  Port-level checker of the dual converter mode sequencer.
  Assumes it is bound to the top module and sees its ports only.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dcms_params.svh"

module dcms_checker (
  input wire logic        ref_clk,         // Core clock
  input wire logic        rst_b,           // Sync reset, active low
  input wire logic        sfr_we,          // Write strobe
  input wire logic [7:0]  sfr_addr,        // Register address
  input wire logic [7:0]  sfr_wdata,       // Write data
  input wire logic        prim_filt_rst,   // Primary reset level
  input wire logic        aux_filt_rst,    // Auxiliary reset level
  input wire logic        prim_pwr_dn,     // Primary powered down
  input wire logic        mod_clk_run,     // Modulator clocks
  input wire logic        prim_in_short,   // Primary input short
  input wire logic        prim_ref_conn,   // Primary reference tie
  input wire logic [6:0]  prim_cfg,        // Primary control fields
  input wire logic [23:0] prim_result_regs // Primary result
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  // Decoded write strobes
  logic wr_mode;
  logic wr_p;
  logic wr_a;
  assign wr_mode = sfr_we && (sfr_addr == `DCMS_ADDR_MODE);
  assign wr_p    = sfr_we && (sfr_addr == `DCMS_ADDR_PCTRL);
  assign wr_a    = sfr_we && (sfr_addr == `DCMS_ADDR_ACTRL);

  // Control fields follow the write; bit 7 never reaches them
  property cfg_p;
    wr_p |=> (prim_cfg == $past(sfr_wdata[6:0]));
  endproperty

  idle_clk_a: assert property (!prim_pwr_dn |-> mod_clk_run)
    else $error("modulator clocks stopped while primary active");
  short_lvl_a: assert property (prim_in_short |-> !prim_pwr_dn && !prim_ref_conn)
    else $error("primary short asserted in wrong state");
  ref_conn_a: assert property (prim_ref_conn |-> !prim_pwr_dn && !prim_in_short)
    else $error("primary reference tie asserted in wrong state");
  mode_rst_a: assert property (wr_mode && !sfr_wdata[`DCMS_MODE_AEN]
                               |-> ##[1:2] (prim_filt_rst && aux_filt_rst))
    else $error("mode write did not reset both converters");
  pctrl_rst_a: assert property (wr_p && !prim_pwr_dn |-> ##[1:2] (prim_filt_rst && aux_filt_rst))
    else $error("primary control write did not reset both");
  aux_rst_a: assert property (wr_a |-> ##[1:2] aux_filt_rst)
    else $error("auxiliary control write did not reset auxiliary");
  aux_keep_a: assert property (wr_a && !prim_filt_rst && !prim_pwr_dn |=> !prim_filt_rst [*2])
    else $error("auxiliary control write disturbed primary");
  cfg_hold_a: assert property (cfg_p)
    else $error("primary control fields not taken from write");
  result_pace_a: assert property ($changed(prim_result_regs)
                                  |=> $stable(prim_result_regs) [*8])
    else $error("primary result updated faster than the cadence");

  // Main scenarios reached
  cover property (prim_in_short);
  cover property (prim_ref_conn);
  cover property (aux_filt_rst && !prim_filt_rst);
  cover property ($changed(prim_result_regs));
endmodule

bind dcms_top dcms_checker i_dcms_checker (
  .ref_clk(ref_clk), .rst_b(rst_b), .sfr_we(sfr_we), .sfr_addr(sfr_addr),
  .sfr_wdata(sfr_wdata), .prim_filt_rst(prim_filt_rst), .aux_filt_rst(aux_filt_rst),
  .prim_pwr_dn(prim_pwr_dn), .mod_clk_run(mod_clk_run), .prim_in_short(prim_in_short),
  .prim_ref_conn(prim_ref_conn), .prim_cfg(prim_cfg), .prim_result_regs(prim_result_regs)
);

`default_nettype wire

// File: testbench/dcms_top_tb_top.sv
/*
  Self-checking bench of the mode sequencer: registers, conversions, calibrations.
  Assumes the design and the checker are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dcms_params.svh"

module dcms_top_tb_top;
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        sfr_we = 1'b0;
  logic        sfr_re = 1'b0;
  logic [7:0]  sfr_addr = 8'h00;
  logic [7:0]  sfr_wdata = 8'h00;
  logic [23:0] prim_raw = 24'h00_0000;
  logic [15:0] aux_raw = 16'h0000;
  logic        prim_clamp = 1'b0;
  logic        aux_clamp = 1'b0;
  logic        ref_missing = 1'b0;
  logic        prim_filt_rst, aux_filt_rst, prim_pwr_dn, aux_pwr_dn, mod_clk_run;
  logic        prim_in_short, aux_in_short, prim_ref_conn, aux_ref_conn;
  logic [6:0]  prim_cfg, aux_cfg;
  logic [7:0]  sfr_rdata, rd_v, seen;
  logic [23:0] prim_result_regs, prim_offset_coef, prim_gain_coef, exp_p, old_p;
  logic [15:0] aux_result_regs, aux_offset_coef, aux_gain_coef, exp_a, exp_ao;
  logic [31:0] seed = 32'ha644_36a8;
  int          err_count = 0;
  int          tests_run = 0;
  int          cyc = 0;
  logic [7:0]  rst_addr [6] = '{8'hd1, 8'hd2, 8'hd3, 8'hd4, 8'hd8, 8'hd5};
  logic [7:0]  rst_val [6] = '{8'h00, 8'h07, 8'h00, 8'h45, 8'h00, 8'h00};

  dcms_top i_dcms_top (
    .ref_clk, .rst_b, .sfr_we, .sfr_re, .sfr_addr, .sfr_wdata, .sfr_rdata, .prim_raw,
    .aux_raw, .prim_clamp, .aux_clamp, .ref_missing, .prim_filt_rst, .aux_filt_rst,
    .prim_pwr_dn, .aux_pwr_dn, .mod_clk_run, .prim_in_short, .aux_in_short, .prim_ref_conn,
    .aux_ref_conn, .prim_cfg, .aux_cfg, .prim_result_regs, .aux_result_regs,
    .prim_offset_coef, .prim_gain_coef, .aux_offset_coef, .aux_gain_coef
  );

  // 40 MHz core clock
  always #12.5 ref_clk = ~ref_clk;

  // Hang guard, far above the thousand or so cycles the tests need
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      summarize();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Mode left after completion: enables kept, code back to power-down
  function automatic logic [7:0] mode_after(input logic [7:0] m);
    return m & 8'h30;
  endfunction

  task automatic chk(input string nm, input logic [23:0] s, input logic [23:0] e);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    sfr_we <= 1'b1;
    sfr_addr <= a;
    sfr_wdata <= d;
    @(posedge ref_clk);
    sfr_we <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    sfr_re <= 1'b1;
    sfr_addr <= a;
    @(posedge ref_clk);
    sfr_re <= 1'b0;
    @(posedge ref_clk);
    #1 rd_v = sfr_rdata;
  endtask

  // Polls a register; the caller compares the last value read
  task automatic wait_reg(input logic [7:0] a, input logic [7:0] m, input logic [7:0] v);
    for (int n = 0; n < 200; n++) begin
      rd(a);
      if ((rd_v & m) === v) break;
    end
  endtask

  // New random filter words, launched on a clock edge
  task automatic setraw();
    @(posedge ref_clk);
    seed = lfsr(seed);
    exp_p = seed[23:0];
    exp_a = seed[31:16];
    prim_raw <= exp_p;
    aux_raw <= exp_a;
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    foreach (rst_addr[i]) begin
      rd(rst_addr[i]);
      chk("reset read", rd_v, rst_val[i]);
    end
    chk("power down", prim_pwr_dn, 1'b1);
    wr(`DCMS_ADDR_RATE, 8'h00);
    $display("test reset finished");
    // idle holds reset, aux stays down
    wr(`DCMS_ADDR_MODE, 8'h21);
    repeat (3) @(posedge ref_clk);
    #1 chk("idle reset", {prim_filt_rst, mod_clk_run, prim_pwr_dn, aux_pwr_dn}, 4'b1101);
    $display("test idle finished");
    setraw();
    prim_clamp <= 1'b1;
    wr(`DCMS_ADDR_MODE, 8'h22);
    wait_reg(`DCMS_ADDR_MODE, 8'h07, 8'h00);
    chk("single mode", rd_v, mode_after(8'h22));
    chk("single result", prim_result_regs, exp_p);
    rd(`DCMS_ADDR_STAT);
    chk("single status", rd_v, 8'h88);
    $display("test single finished");
    @(posedge ref_clk);
    prim_clamp <= 1'b0;
    wr(`DCMS_ADDR_MODE, 8'h23);
    wait_reg(`DCMS_ADDR_STAT, 8'h80, 8'h80);
    chk("cont result", prim_result_regs, exp_p);
    old_p = exp_p;
    setraw();
    repeat (100) @(posedge ref_clk);
    chk("blocked result", prim_result_regs, old_p);
    wr(`DCMS_ADDR_STAT, 8'h00);
    wait_reg(`DCMS_ADDR_STAT, 8'h80, 8'h80);
    chk("cont refresh", prim_result_regs, exp_p);
    // auxiliary control write keeps primary running
    wr(`DCMS_ADDR_ACTRL, 8'h88);
    repeat (2) @(posedge ref_clk);
    #1 chk("aux fields", aux_cfg, 7'h08);
    chk("primary running", prim_filt_rst, 1'b0);
    wr(`DCMS_ADDR_MODE, 8'h23);
    #1 seen = {7'h00, prim_filt_rst};
    @(posedge ref_clk);
    #1 seen = seen | {7'h00, prim_filt_rst};
    chk("rewrite reset", seen, 8'h01);
    $display("test continuous finished");
    // every calibration code, random reference select
    for (int c = 4; c < 8; c++) begin
      // system inputs settled before the request
      setraw();
      wr(`DCMS_ADDR_PCTRL, {1'b1, seed[6], 6'h07});
      #1 chk("ctrl fields", prim_cfg, {seed[6], 6'h07});
      wr(`DCMS_ADDR_MODE, 8'h30 | 8'(c));
      rd(`DCMS_ADDR_STAT);
      chk("ready cleared", rd_v & 8'hc0, 8'h00);
      chk("short", {prim_in_short, aux_in_short}, {2{c == 4}});
      chk("ref tie", {prim_ref_conn, aux_ref_conn}, {2{c == 5}});
      wait_reg(`DCMS_ADDR_MODE, 8'hff, 8'h30);
      chk("cal mode", rd_v, mode_after(8'h30));
      rd(`DCMS_ADDR_STAT);
      chk("cal status", rd_v & 8'he0, 8'he0);
      chk("p coef", c[0] ? prim_gain_coef : prim_offset_coef, exp_p);
      chk("a coef", c[0] ? aux_gain_coef : aux_offset_coef, exp_a);
      if (!c[0]) begin
        exp_ao = exp_a;
      end
    end
    $display("test calibration finished");
    // auxiliary calibration on the temperature sensor
    setraw();
    wr(`DCMS_ADDR_ACTRL, 8'h20);
    wr(`DCMS_ADDR_MODE, 8'h14);
    wait_reg(`DCMS_ADDR_MODE, 8'hff, 8'h10);
    rd(`DCMS_ADDR_STAT);
    chk("temp status", rd_v & 8'h44, 8'h44);
    chk("temp coef", aux_offset_coef, exp_ao);
    $display("test temperature finished");
    // both converters continuous, reference absent flagged
    setraw();
    ref_missing <= 1'b1;
    wr(`DCMS_ADDR_MODE, 8'h33);
    wait_reg(`DCMS_ADDR_STAT, 8'hc0, 8'hc0);
    chk("both status", rd_v & 8'hd0, 8'hd0);
    chk("aux result", aux_result_regs, exp_a);
    // aux-only reset realigns within three periods of 16 cycles
    setraw();
    wr(`DCMS_ADDR_STAT, 8'h80);
    wr(`DCMS_ADDR_ACTRL, 8'h08);
    repeat (50) @(posedge ref_clk);
    #1 chk("aux aligned", aux_result_regs, exp_a);
    $display("test auxiliary finished");
    summarize();
  end
endmodule

`default_nettype wire
